//--- timebase_pkg.sv
// How it works
// [R1] Source select high picks external input, low oscillator
// [R2] External source advances on each falling edge
// [R3] Decade first stage clocks later synchronous stages
// [R4] Multiplexer picks one stage for time output
// [R5] Ratios span one to thirty-six hundred million
// [R6] Binary selector code maps to mode or function
// [R7] Code 0000 passes selected source straight through
// [R8] Codes 1100 and 1101 force output constant
// [R9] Code 1111 passes external input straight through
// [R10] Output is square wave at source over ratio
// [R11] Consumers trigger on falling output edge only
// [R12] Long high clear pulse sets counters lowest
// [R13] Long high preset pulse sets counters highest
// [R14] After preset next source edge gives falling output
// [R15] Test level on reset pins bypasses chain portions
// [R16] Hold low freezes oscillator; first cycle complete
// [R17] Decade periods plus minute, ten-minute, hour ratios
// [R18] Divide-by-twenty-thousand mode gives line frequency
// [R19] Four weighted selector inputs choose the ratio
// [R20] Hold must stay low half an oscillator period
// [R21] Held reset keeps counters; resume on next edge
package timebase_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLOCK_PERIOD_NS    = 4;
  localparam int unsigned RESET_PULSE_NS     = 10000;
  localparam int unsigned RESET_PULSE_CYCLES =
    (RESET_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [11:0] RESET_PULSE_COUNT  = 12'(RESET_PULSE_CYCLES);
  localparam logic [7:0]  OSC_HALF_CYCLES    = 8'h7D;

  // ----------------------------------------------------------------
  // Pin vector positions
  // ----------------------------------------------------------------
  localparam int unsigned PIN_COUNT       = 11;
  localparam int unsigned PIN_EXT         = 0;
  localparam int unsigned PIN_SRC_SEL     = 1;
  localparam int unsigned PIN_CLEAR       = 2;
  localparam int unsigned PIN_PRESET      = 3;
  localparam int unsigned PIN_TEST_CLEAR  = 4;
  localparam int unsigned PIN_TEST_PRESET = 5;
  localparam int unsigned PIN_HOLD_N      = 6;
  localparam int unsigned PIN_SEL_LO      = 7;

  // ----------------------------------------------------------------
  // Selector codes
  // ----------------------------------------------------------------
  localparam logic [3:0] CODE_PASS_SOURCE = 4'h0;
  localparam logic [3:0] CODE_FORCE_A     = 4'hC;
  localparam logic [3:0] CODE_FORCE_B     = 4'hD;
  localparam logic [3:0] CODE_PASS_EXT    = 4'hF;
  localparam logic       FORCED_LEVEL     = 1'b0;

  // ----------------------------------------------------------------
  // Counter stages: moduli and which stage wrap feeds each one
  // ----------------------------------------------------------------
  localparam int unsigned STAGE_COUNT = 12;
  localparam int unsigned FEED_SOURCE = 15;
  localparam logic [3:0] STAGE_MOD [STAGE_COUNT] = '{
    4'hA, 4'hA, 4'hA, 4'hA, 4'hA, 4'hA, 4'hA, 4'hA,
    4'h6, 4'h6, 4'h6, 4'h2};
  localparam int unsigned STAGE_FEED [STAGE_COUNT] = '{
    FEED_SOURCE, 0, 1, 2, 3, 4, 5, 6, 6, 7, 9, 3};

  function automatic logic [3:0] code_stage(input logic [3:0] code);
    case (code)
      4'h1:    code_stage = 4'h0;
      4'h2:    code_stage = 4'h1;
      4'h3:    code_stage = 4'h2;
      4'h4:    code_stage = 4'h3;
      4'h5:    code_stage = 4'h4;
      4'h6:    code_stage = 4'h5;
      4'h7:    code_stage = 4'h6;
      4'h8:    code_stage = 4'h7;
      4'h9:    code_stage = 4'h8;
      4'hA:    code_stage = 4'h9;
      4'hB:    code_stage = 4'hA;
      4'hE:    code_stage = 4'hB;
      default: code_stage = 4'h0;
    endcase
  endfunction : code_stage

endpackage : timebase_pkg

//--- stage_if.sv
`timescale 1ns/1ns
`default_nettype none
interface stage_if;
  logic       step;
  logic       load_min;
  logic       load_max;
  logic       wrap;
  logic       out_high;
  logic [3:0] digit;
  modport stage (input step, input load_min, input load_max,
                 output wrap, output out_high, output digit);
  modport chain (output step, output load_min, output load_max,
                 input wrap, input out_high, input digit);
endinterface : stage_if
`default_nettype wire

//--- digit_stage.sv
`timescale 1ns/1ns
`default_nettype none
module digit_stage
  import timebase_pkg::*;
#(
  parameter logic [3:0] MODULUS = 4'hA
) (
  input wire logic clock,   // System clock
  input wire logic reset_n, // Asynchronous reset
  stage_if.stage   port     // Step, loads and stage state
);
  localparam logic [3:0] TOP  = MODULUS - 4'h1;
  localparam logic [3:0] HALF = MODULUS >> 1;

  logic [3:0] digit_q;
  logic [3:0] digit_d;
  logic       at_top;

  assign at_top        = (digit_q == TOP);
  assign port.wrap     = port.step & at_top;
  // High in the upper half so that wrapping from the top gives a falling edge.
  assign port.out_high = (digit_q >= HALF); // [R10]
  assign port.digit    = digit_q;
  assign digit_d = port.load_min ? 4'h0 :
                   port.load_max ? TOP : // [R14]
                   !port.step    ? digit_q :
                   at_top        ? 4'h0 : digit_q + 4'h1;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      digit_q <= 4'h0;
    end else begin
      digit_q <= digit_d; // [R3]
    end
  end

  property p_wrap_zero;
    @(posedge clock) disable iff (!reset_n)
      port.wrap && !port.load_min && !port.load_max |=> digit_q == 4'h0;
  endproperty
  a_wrap_zero: assert property (p_wrap_zero) else $error("stage did not wrap"); // [R3]

endmodule : digit_stage
`default_nettype wire

//--- timebase_divider.sv
`timescale 1ns/1ns
`default_nettype none
module timebase_divider
  import timebase_pkg::*;
(
  input  wire logic       clock,             // 250 MHz system clock
  input  wire logic       reset_n,           // Asynchronous reset
  input  wire logic       external_pulse_in, // External pulse train
  input  wire logic       source_select,     // High picks external input
  input  wire logic       clear_min,         // Clear counters pulse
  input  wire logic       preset_max,        // Preset counters pulse
  input  wire logic       test_clear,        // Test level on clear pin
  input  wire logic       test_preset,       // Test level on preset pin
  input  wire logic       osc_hold_n,        // Low holds the oscillator
  input  wire logic [3:0] division_select,   // Division selector code
  output logic            time_out,          // Time-base output
  output logic            osc_out            // Internal oscillator level
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // A level is taken only once the second and third stages agree,
  // which rejects a single metastable sample.

  logic [PIN_COUNT-1:0] pins_raw;
  logic [PIN_COUNT-1:0] sync1_q;
  logic [PIN_COUNT-1:0] sync2_q;
  logic [PIN_COUNT-1:0] sync3_q;
  logic [PIN_COUNT-1:0] level_q;
  logic [PIN_COUNT-1:0] level_d;
  logic [PIN_COUNT-1:0] agree;

  assign pins_raw = {division_select, osc_hold_n, test_preset,
                     test_clear, preset_max, clear_min,
                     source_select, external_pulse_in};
  assign agree    = ~(sync2_q ^ sync3_q);
  assign level_d  = (agree & sync3_q) | (~agree & level_q);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      level_q <= '0;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      level_q <= level_d;
    end
  end

  logic       ext_level;
  logic       src_sel_level;
  logic       clear_level;
  logic       preset_level;
  logic       test_mode;
  logic       hold_level;
  logic [3:0] code;

  assign ext_level     = level_q[PIN_EXT];
  assign src_sel_level = level_q[PIN_SRC_SEL];
  assign clear_level   = level_q[PIN_CLEAR];
  assign preset_level  = level_q[PIN_PRESET];
  assign test_mode     = level_q[PIN_TEST_CLEAR] | level_q[PIN_TEST_PRESET];
  assign hold_level    = level_q[PIN_HOLD_N];
  assign code          = level_q[PIN_SEL_LO +: 4]; // [R19]

  // ----------------------------------------------------------------
  // Reset pulse qualifiers
  // ----------------------------------------------------------------
  // A pulse acts only after it has been high for the full minimum
  // width; a shorter glitch never disturbs the count.

  logic [1:0]  qual_pin;
  logic [1:0]  qual_done;
  logic        clear_act;
  logic        preset_act;

  assign qual_pin = {preset_level, clear_level};

  for (genvar q = 0; q < 2; q++) begin : g_qual
    logic [11:0] cnt_q;
    logic [11:0] cnt_d;
    assign qual_done[q] = (cnt_q == RESET_PULSE_COUNT);
    assign cnt_d = !qual_pin[q]  ? 12'h000 :
                   qual_done[q]  ? cnt_q :
                   cnt_q + 12'h001;
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        cnt_q <= 12'h000;
      end else begin
        cnt_q <= cnt_d; // [R12] [R13]
      end
    end
  end

  // Held pulses keep loading the stages every cycle.
  assign clear_act  = qual_done[0]; // [R12] [R21]
  assign preset_act = qual_done[1] & ~qual_done[0]; // [R13] [R21]

  // ----------------------------------------------------------------
  // Internal oscillator
  // ----------------------------------------------------------------
  // While held the oscillator rests low with its phase counter at zero,
  // so the first cycle after release is a full low then high period.

  logic [7:0] osc_cnt_q;
  logic [7:0] osc_cnt_d;
  logic       osc_level_q;
  logic       osc_level_d;
  logic       osc_half_end;
  logic       osc_fall;

  assign osc_half_end = (osc_cnt_q == OSC_HALF_CYCLES - 8'h01);
  assign osc_fall     = hold_level & osc_half_end & osc_level_q;
  assign osc_cnt_d    = (!hold_level || osc_half_end) ? 8'h00
                                                      : osc_cnt_q + 8'h01;
  assign osc_level_d  = !hold_level  ? 1'b0 :
                        osc_half_end ? ~osc_level_q : osc_level_q;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      osc_cnt_q   <= 8'h00;
      osc_level_q <= 1'b0;
    end else begin
      osc_cnt_q   <= osc_cnt_d; // [R16]
      osc_level_q <= osc_level_d;
    end
  end

  // ----------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------

  logic ext_prev_q;
  logic ext_fall;
  logic src_level;
  logic src_step;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ext_prev_q <= 1'b0;
    end else begin
      ext_prev_q <= ext_level;
    end
  end

  assign ext_fall  = ext_prev_q & ~ext_level; // [R2]
  assign src_level = src_sel_level ? ext_level : osc_level_q; // [R1]
  assign src_step  = src_sel_level ? ext_fall : osc_fall; // [R1] [R2]

  // ----------------------------------------------------------------
  // Counter chain
  // ----------------------------------------------------------------
  // Every stage runs on the system clock; the stage that feeds it only
  // grants a step, so the whole chain stays synchronous. In test mode
  // each stage steps straight from the source, bypassing those below.

  logic [STAGE_COUNT-1:0] stage_wrap;
  logic [STAGE_COUNT-1:0] stage_high;
  logic [STAGE_COUNT-1:0] stage_min;
  logic [STAGE_COUNT-1:0] stage_max;
  logic [STAGE_COUNT-1:0] feed_step;
  logic [3:0]             stage_digit [STAGE_COUNT];

  for (genvar i = 0; i < STAGE_COUNT; i++) begin : g_stage
    stage_if link ();

    if (STAGE_FEED[i] == FEED_SOURCE) begin : g_first
      assign feed_step[i] = src_step; // [R3]
    end else begin : g_later
      assign feed_step[i] = stage_wrap[STAGE_FEED[i]]; // [R3]
    end

    assign link.step      = test_mode ? src_step : feed_step[i]; // [R15]
    assign link.load_min  = clear_act;
    assign link.load_max  = preset_act;
    assign stage_wrap[i]  = link.wrap;
    assign stage_high[i]  = link.out_high;
    assign stage_digit[i] = link.digit;
    assign stage_min[i]   = (link.digit == 4'h0);
    assign stage_max[i]   = (link.digit == STAGE_MOD[i] - 4'h1);

    digit_stage #(
      .MODULUS (STAGE_MOD[i])
    ) u_stage (
      .clock   (clock),
      .reset_n (reset_n),
      .port    (link)
    );
  end

  logic chain_all_min;
  logic chain_all_max;

  assign chain_all_min = &stage_min;
  assign chain_all_max = &stage_max;

  // ----------------------------------------------------------------
  // Output selection
  // ----------------------------------------------------------------
  // Codes one to eight give decades up to a hundred million, nine to
  // eleven the minute, ten-minute and hour ratios, fourteen twenty
  // thousand for line frequency from a 1 or 1.2 MHz source.

  logic [3:0] sel_stage;
  logic       divided;
  logic       is_pass_src;
  logic       is_forced;
  logic       is_pass_ext;
  logic       is_divide;
  logic       next_out;
  logic       time_out_q;
  logic       osc_out_q;

  assign sel_stage   = code_stage(code); // [R6] [R17] [R18]
  assign divided     = stage_high[sel_stage]; // [R4] [R5]
  assign is_pass_src = (code == CODE_PASS_SOURCE);
  assign is_forced   = (code == CODE_FORCE_A) | (code == CODE_FORCE_B);
  assign is_pass_ext = (code == CODE_PASS_EXT);
  assign is_divide   = ~(is_pass_src | is_forced | is_pass_ext);
  assign next_out    = is_pass_src ? src_level : // [R7]
                       is_forced   ? FORCED_LEVEL : // [R8]
                       is_pass_ext ? ext_level : // [R9]
                       divided; // [R10] [R11]

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      time_out_q <= 1'b0;
      osc_out_q  <= 1'b0;
    end else begin
      time_out_q <= next_out;
      osc_out_q  <= osc_level_q;
    end
  end

  assign time_out = time_out_q;
  assign osc_out  = osc_out_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  // Remembers that a preset has loaded the chain and no step has come.
  logic armed_q;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      armed_q <= 1'b0;
    end else if (preset_act) begin
      armed_q <= 1'b1;
    end else if (src_step || test_mode || clear_act) begin
      armed_q <= 1'b0;
    end
  end

  property p_ext_counts;
    @(posedge clock) disable iff (!reset_n)
      src_sel_level && ext_fall && !clear_act && !preset_act && !test_mode
      |=> stage_digit[0] == (($past(stage_digit[0]) == 4'h9) ? 4'h0
                             : $past(stage_digit[0]) + 4'h1);
  endproperty
  a_ext_counts: assert property (p_ext_counts) else $error("external edge not counted"); // [R2]

  property p_int_ignores_ext;
    @(posedge clock) disable iff (!reset_n)
      !src_sel_level && ext_fall && !osc_fall && !clear_act && !preset_act
      |=> $stable(stage_digit[0]);
  endproperty
  a_int_ignores_ext: assert property (p_int_ignores_ext) else $error("wrong source counted"); // [R1]

  property p_chain_carry;
    @(posedge clock) disable iff (!reset_n)
      stage_wrap[0] && !test_mode && !clear_act && !preset_act
      |=> stage_digit[1] != $past(stage_digit[1]);
  endproperty
  a_chain_carry: assert property (p_chain_carry) else $error("first stage did not clock next"); // [R3]

  property p_pass_source;
    @(posedge clock) disable iff (!reset_n)
      is_pass_src |=> time_out == $past(src_level);
  endproperty
  a_pass_source: assert property (p_pass_source) else $error("source not passed through"); // [R7]

  property p_force_level;
    @(posedge clock) disable iff (!reset_n)
      is_forced ##1 is_forced |-> time_out == FORCED_LEVEL;
  endproperty
  a_force_level: assert property (p_force_level) else $error("output not forced"); // [R8]

  property p_pass_ext;
    @(posedge clock) disable iff (!reset_n)
      is_pass_ext |=> time_out == $past(ext_level);
  endproperty
  a_pass_ext: assert property (p_pass_ext) else $error("external input not passed"); // [R9]

  property p_clear_min;
    @(posedge clock) disable iff (!reset_n)
      clear_act |=> chain_all_min;
  endproperty
  a_clear_min: assert property (p_clear_min) else $error("clear did not reach lowest state"); // [R12]

  property p_clear_needs_pin;
    @(posedge clock) disable iff (!reset_n)
      !clear_level |=> !clear_act;
  endproperty
  a_clear_needs_pin: assert property (p_clear_needs_pin) else $error("clear without pin"); // [R12]

  property p_preset_max;
    @(posedge clock) disable iff (!reset_n)
      preset_act |=> chain_all_max;
  endproperty
  a_preset_max: assert property (p_preset_max) else $error("preset did not reach highest state"); // [R13]

  property p_held_stays;
    @(posedge clock) disable iff (!reset_n)
      clear_act [*2] |-> chain_all_min;
  endproperty
  a_held_stays: assert property (p_held_stays) else $error("counters moved under reset"); // [R21]

  property p_first_fall;
    @(posedge clock) disable iff (!reset_n)
      armed_q && !preset_act && !clear_act && src_step && is_divide
      && !test_mode && $stable(code) |=> ##1 $fell(time_out);
  endproperty
  a_first_fall: assert property (p_first_fall) else $error("no falling edge after preset"); // [R14]

  property p_hold_freeze;
    @(posedge clock) disable iff (!reset_n)
      !hold_level |=> !osc_level_q && osc_cnt_q == 8'h00;
  endproperty
  a_hold_freeze: assert property (p_hold_freeze) else $error("oscillator not held"); // [R16]

  property p_full_first_cycle;
    @(posedge clock) disable iff (!reset_n)
      $rose(hold_level) |-> !osc_fall [*8];
  endproperty
  a_full_first_cycle: assert property (p_full_first_cycle) else $error("short first cycle"); // [R16]

endmodule : timebase_divider
`default_nettype wire

//--- pulse_source.sv
`timescale 1ns/1ns
`default_nettype none
module pulse_source (
  input  wire logic clock,    // System clock
  input  wire logic time_out, // Time base being consumed
  output var logic  ext_pin,  // Pulse train into the divider
  output var int    falls     // Falling time-base edges seen
);
  logic last_q;

  initial begin
    ext_pin = 1'h1;
    falls = 0;
    last_q = 1'h0;
  end

  // ------------------------------------------------------------------
  // Consumer
  // ------------------------------------------------------------------
  // Only falling edges are used, since the high time depends on the mode.
  always @(posedge clock) begin
    if (last_q === 1'h1 && time_out === 1'h0) begin
      falls <= falls + 1;
    end
    last_q <= time_out;
  end

  // ------------------------------------------------------------------
  // Pulse generator
  // ------------------------------------------------------------------
  // Each level lasts 50 clocks, the 200 ns minimum; the idle level is high.
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      #1 ext_pin = 1'h0;
      repeat (50) @(posedge clock);
      #1 ext_pin = 1'h1;
      repeat (49) @(posedge clock);
    end
    // Return off the edge so the caller never drives pins in the sampling step.
    #1;
  endtask : pulses
endmodule : pulse_source
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb
  import timebase_pkg::*;
  ;
  logic       clock;
  logic       reset_n;
  logic       ext_pin;
  logic       source_select;
  logic       clear_min;
  logic       preset_max;
  logic       test_clear;
  logic       test_preset;
  logic       osc_hold_n;
  logic [3:0] division_select;
  logic       time_out;
  logic       osc_out;
  int         falls;
  int         mark;
  int         mismatches;
  int         checks_done;

  timebase_divider timebase_divider_i (
    .clock             (clock),
    .reset_n           (reset_n),
    .external_pulse_in (ext_pin),
    .source_select     (source_select),
    .clear_min         (clear_min),
    .preset_max        (preset_max),
    .test_clear        (test_clear),
    .test_preset       (test_preset),
    .osc_hold_n        (osc_hold_n),
    .division_select   (division_select),
    .time_out          (time_out),
    .osc_out           (osc_out)
  );

  pulse_source pulse_source_i (
    .clock    (clock),
    .time_out (time_out),
    .ext_pin  (ext_pin),
    .falls    (falls)
  );

  initial begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_pass;
    logic [3:0] codes [4];
    logic       sels  [4];
    logic       highs [4];
    codes = '{4'h0, 4'hF, 4'hC, 4'hD};
    sels = '{1'h1, 1'h0, 1'h1, 1'h1};
    highs = '{1'h1, 1'h1, FORCED_LEVEL, FORCED_LEVEL};
    for (int i = 0; i < 4; i++) begin
      source_select = sels[i];
      division_select = codes[i];
      cyc(10);
      check("idle level", time_out, highs[i]);
      fork
        pulse_source_i.pulses(1);
        begin
          cyc(25);
          check("low level", time_out, (i < 2) ? 1'h0 : FORCED_LEVEL);
          cyc(50);
          check("high level", time_out, highs[i]);
        end
      join
    end
  endtask : t_pass

  task automatic t_divide;
    source_select = 1'h1;
    division_select = 4'h1;
    clear_min = 1'h1;
    cyc(2600);
    check("cleared", time_out, 1'h0);
    mark = falls;
    pulse_source_i.pulses(10);
    check("held falls", 32'(falls - mark), 32'h0);
    clear_min = 1'h0;
    cyc(5);
    pulse_source_i.pulses(5);
    check("upper half", time_out, 1'h1);
    pulse_source_i.pulses(5);
    check("div10 falls", 32'(falls - mark), 32'h1);
    check("wrapped", time_out, 1'h0);
    division_select = 4'h2;
    cyc(10);
    mark = falls;
    pulse_source_i.pulses(100);
    check("div100 falls", 32'(falls - mark), 32'h1);
  endtask : t_divide

  task automatic t_preset;
    logic [3:0] codes [4];
    codes = '{4'h1, 4'h9, 4'hB, 4'hE};
    for (int i = 0; i < 4; i++) begin
      division_select = codes[i];
      preset_max = 1'h1;
      cyc(2600);
      check("preset level", time_out, 1'h1);
      preset_max = 1'h0;
      clear_min = 1'h1;
      cyc(100);
      clear_min = 1'h0;
      cyc(10);
      check("short clear", time_out, 1'h1);
      mark = falls;
      fork
        pulse_source_i.pulses(1);
        begin
          cyc(12);
          check("first fall", 32'(falls - mark), 32'h1);
        end
      join
    end
  endtask : t_preset

  task automatic t_test;
    source_select = 1'h1;
    division_select = 4'h3;
    for (int i = 0; i < 2; i++) begin
      test_clear = 1'(i == 0);
      test_preset = 1'(i == 1);
      cyc(10);
      mark = falls;
      pulse_source_i.pulses(20);
      cyc(10);
      check("bypass falls", 32'(falls - mark), 32'h2);
    end
    test_preset = 1'h0;
    cyc(10);
  endtask : t_test

  task automatic t_osc;
    source_select = 1'h0;
    division_select = 4'h1;
    // Held low far longer than half an oscillator period.
    osc_hold_n = 1'h0;
    clear_min = 1'h1;
    cyc(2600);
    check("held osc", osc_out, 1'h0);
    clear_min = 1'h0;
    cyc(5);
    mark = falls;
    osc_hold_n = 1'h1;
    cyc(60);
    check("osc first low", osc_out, 1'h0);
    cyc(140);
    check("osc first high", osc_out, 1'h1);
    cyc(1300);
    check("osc div upper", time_out, 1'h1);
    cyc(900);
    check("osc early", 32'(falls - mark), 32'h0);
    cyc(200);
    check("osc div10", 32'(falls - mark), 32'h1);
    osc_hold_n = 1'h0;
  endtask : t_osc

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    reset_n = 1'h0;
    source_select = 1'h0;
    clear_min = 1'h0;
    preset_max = 1'h0;
    test_clear = 1'h0;
    test_preset = 1'h0;
    osc_hold_n = 1'h0;
    division_select = 4'h0;
    mismatches = 0;
    checks_done = 0;
    cyc(12);
    reset_n = 1'h1;
    cyc(10);
    t_pass();
    t_divide();
    t_preset();
    t_test();
    t_osc();
    give_verdict();
  end

  // A hung sequence is cut short here and still gets a verdict.
  initial begin
    repeat (100000) @(posedge clock);
    mismatches++;
    $display("Error run_time expected end seen limit");
    give_verdict();
  end
endmodule : tb
`default_nettype wire
